// ===== design/position_fault_stop_logic.sv
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
// How it works
// - A fault during position control stops per fault_stop_select: 0 coasts, 1 ramps down.
// - Coast blocks output at once and closes the brake in that same cycle when brake use is on.
// - Ramp stop lowers output by one step every fault_ramp_time cycles and then blocks output.
// - During a ramp stop with brake use on, the brake closes once output reaches brake_close_frequency.
// - Upper and lower hard bound switches and soft bound levels are watched as fault sources.
// - With upper_soft_bound_en at 0 the upper soft bound never faults.
// - With lower_soft_bound_en at 0 the lower soft bound never faults.
// - Soft bound levels are in user units and writable only while soft_bound_function is 1.
// - While running, commanded versus measured position beyond tracking_error_limit faults.
// - Target versus present position beyond target_window_limit raises a target error.
// - Encoder pulses update the present position, which software may overwrite.
// - Homing inputs move at the homing speed, then at homing_slow_percent of it on the home switch, and set the reference by the chosen method.
// - When homing ends the present position takes preset_position and the motor stops.
module position_fault_stop_logic
   import pos_fault_pkg::*;
(
   input wire logic pclk, // APB clock, 20 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable; freezes all state when low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire field_in_type field_in, // Switches, encoder and homing inputs.
   output drive_out_type drive_out, // Gate block, brake, output level, direction.
   output logic irq // Level interrupt.
);
   logic [31:0] control;
   logic [31:0] upper_soft_bound_level;
   logic [31:0] lower_soft_bound_level;
   logic [31:0] tracking_error_limit;
   logic [31:0] target_window_limit;
   logic [31:0] fault_ramp_time;
   logic [15:0] brake_close_frequency;
   logic [31:0] commanded_position;
   logic [31:0] selected_target_position;
   logic [31:0] preset_position;
   logic [15:0] homing_speed;
   logic [31:0] homing_ramp;
   logic [15:0] run_level;
   logic [ev_width-1:0] irq_status;
   logic [ev_width-1:0] irq_mask;
   logic [ev_width-1:0] fault_latch;
   logic [ev_width-1:0] events;
   logic [31:0] present_position;
   logic [31:0] ramp_count;
   logic [15:0] level;
   logic brake;
   logic blocked;
   logic dir_rev;
   logic home_prev;
   logic index_prev;
   logic pos_load;
   logic [31:0] pos_load_value;
   logic sw_pos_write;
   logic home_load;
   logic any_fault;
   logic wr;
   logic rd;
   logic addr_ok;
   logic running;
   stop_state_type state;
   stop_state_type next_state;

   assign wr = psel && penable && pwrite && ce;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;
   assign running = control[ctl_run];

   always_comb begin
      unique case (paddr)
         off_control, off_status, off_irq_status, off_irq_mask,
         off_upper_soft_bound_level, off_lower_soft_bound_level,
         off_tracking_error_limit, off_target_window_limit, off_fault_ramp_time,
         off_brake_close_frequency, off_commanded_position,
         off_selected_target_position, off_present_position, off_preset_position,
         off_homing_speed, off_homing_ramp, off_output_level: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // Configuration writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= control_reset;
         tracking_error_limit <= limit_reset;
         target_window_limit <= limit_reset;
         fault_ramp_time <= ramp_time_reset;
         brake_close_frequency <= 16'h0000;
         commanded_position <= 32'h0000_0000;
         selected_target_position <= 32'h0000_0000;
         preset_position <= 32'h0000_0000;
         homing_speed <= 16'h0000;
         homing_ramp <= ramp_time_reset;
         run_level <= 16'h0000;
         irq_mask <= '0;
      end else if (wr) begin
         unique case (paddr)
            off_control: control <= pwdata;
            off_irq_mask: irq_mask <= pwdata[ev_width-1:0];
            off_tracking_error_limit: tracking_error_limit <= pwdata;
            off_target_window_limit: target_window_limit <= pwdata;
            off_fault_ramp_time: fault_ramp_time <= pwdata;
            off_brake_close_frequency: brake_close_frequency <= pwdata[15:0];
            off_commanded_position: commanded_position <= pwdata;
            off_selected_target_position: selected_target_position <= pwdata;
            off_preset_position: preset_position <= pwdata;
            off_homing_speed: homing_speed <= pwdata[15:0];
            off_homing_ramp: homing_ramp <= pwdata;
            off_output_level: run_level <= pwdata[15:0];
            default: control <= control;
         endcase
      end
   end

   // Soft bound levels accept writes only with the soft bound function on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upper_soft_bound_level <= limit_reset;
         lower_soft_bound_level <= 32'h8000_0000;
      end else if (wr && control[ctl_soft_bound_function]) begin
         if (paddr == off_upper_soft_bound_level) begin
            upper_soft_bound_level <= pwdata;
         end
         if (paddr == off_lower_soft_bound_level) begin
            lower_soft_bound_level <= pwdata;
         end
      end
   end

   // Fault sources; soft bounds compare signed user-unit positions.
   always_comb begin
      events = '0;
      events[ev_upper_hard] = field_in.upper_hard;
      events[ev_lower_hard] = field_in.lower_hard;
      events[ev_upper_soft] = control[ctl_upper_soft_bound_en] &&
         ($signed(present_position) > $signed(upper_soft_bound_level));
      events[ev_lower_soft] = control[ctl_lower_soft_bound_en] &&
         ($signed(present_position) < $signed(lower_soft_bound_level));
      events[ev_tracking] = running &&
         (abs_diff(commanded_position, present_position) > tracking_error_limit);
      events[ev_target] =
         abs_diff(selected_target_position, present_position) > target_window_limit;
      events[ev_stop_done] = (state == st_ramp) && (level == 16'h0000);
      events[ev_home_done] = home_load;
   end
   // Target error is reported but does not itself stop the drive.
   assign any_fault = |events[ev_tracking:ev_upper_hard] && !events[ev_target] ||
      |events[ev_lower_soft:ev_upper_hard] || events[ev_tracking];

   // Sticky status; a new event wins over a write-one clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= '0;
      end else if (ce) begin
         irq_status <= (irq_status & ~((wr && paddr == off_irq_status) ?
            pwdata[ev_width-1:0] : '0)) | events;
      end
   end
   assign irq = |(irq_status & irq_mask);

   // Stop sequence state machine.
   always_comb begin
      next_state = state;
      unique case (state)
         st_idle: begin
            if (field_in.run_home) begin
               next_state = st_home_fast;
            end else if (running) begin
               next_state = st_run;
            end
         end
         st_run: begin
            if (any_fault) begin
               next_state = control[ctl_fault_stop_select] ? st_ramp : st_stopped;
            end else if (!running) begin
               next_state = st_idle;
            end
         end
         st_ramp: if (level == 16'h0000) next_state = st_stopped;
         st_stopped: if (!running && !field_in.run_home) next_state = st_idle;
         st_home_fast: if (field_in.home_switch) next_state = st_home_slow;
         st_home_slow: if (home_load) next_state = st_stopped;
         default: next_state = st_idle;
      endcase
   end

   // Home completes when the home switch releases: at the next index pulse for
   // the index methods, at once otherwise.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         home_prev <= 1'b0;
         index_prev <= 1'b0;
         home_load <= 1'b0;
      end else if (ce) begin
         home_prev <= field_in.home_switch;
         index_prev <= field_in.enc_index;
         home_load <= 1'b0;
         if (state == st_home_slow && !field_in.home_switch && !home_load) begin
            if (control[ctl_homing_method_lo] == 1'b1) begin
               home_load <= home_prev;
            end else begin
               home_load <= field_in.enc_index && !index_prev;
            end
         end
      end
   end

   assign sw_pos_write = wr && paddr == off_present_position;
   assign pos_load = sw_pos_write || home_load;
   assign pos_load_value = home_load ? preset_position : pwdata;

   quad_counter counter (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .enc_a(field_in.enc_a),
      .enc_b(field_in.enc_b),
      .load(pos_load),
      .load_value(pos_load_value),
      .position(present_position)
   );

   // First fault latch held until the stopped state returns to idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_latch <= '0;
      end else if (ce) begin
         if (state == st_run && any_fault) begin
            fault_latch <= events;
         end else if (state == st_stopped && next_state == st_idle) begin
            fault_latch <= '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Output level, ramp, gate block and brake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 16'h0000;
         ramp_count <= 32'h0000_0000;
         blocked <= 1'b1;
         brake <= 1'b1;
         dir_rev <= 1'b0;
      end else if (ce) begin
         unique case (next_state)
            st_run: begin
               level <= run_level;
               blocked <= 1'b0;
               brake <= 1'b0;
            end
            st_ramp: begin
               blocked <= 1'b0;
               if (ramp_count + 32'h0000_0001 >= fault_ramp_time) begin
                  ramp_count <= 32'h0000_0000;
                  level <= (level == 16'h0000) ? level : level - 16'h0001;
               end else begin
                  ramp_count <= ramp_count + 32'h0000_0001;
               end
               if (control[ctl_brake_enable] && level <= brake_close_frequency) begin
                  brake <= 1'b1;
               end
            end
            st_stopped: begin
               level <= 16'h0000;
               blocked <= 1'b1;
               brake <= control[ctl_brake_enable] ? 1'b1 : brake;
            end
            st_home_fast: begin
               level <= homing_speed;
               blocked <= 1'b0;
               brake <= 1'b0;
               dir_rev <= !control[ctl_homing_method_lo+1];
            end
            st_home_slow: begin
               level <= 16'((32'(homing_speed) * homing_slow_percent) / 100);
               // Reverse methods turn round at the home switch; forward ones keep going.
               dir_rev <= 1'b0;
            end
            default: begin
               level <= 16'h0000;
               blocked <= 1'b1;
            end
         endcase
      end
   end

   assign drive_out.gate_block = blocked;
   assign drive_out.brake_close = brake;
   assign drive_out.output_level = level;
   assign drive_out.dir_reverse = dir_rev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && rd && !penable) begin
         unique case (paddr)
            off_control: prdata <= control;
            off_status: prdata <= {21'h0, state, fault_latch};
            off_irq_status: prdata <= {24'h0, irq_status};
            off_irq_mask: prdata <= {24'h0, irq_mask};
            off_upper_soft_bound_level: prdata <= upper_soft_bound_level;
            off_lower_soft_bound_level: prdata <= lower_soft_bound_level;
            off_tracking_error_limit: prdata <= tracking_error_limit;
            off_target_window_limit: prdata <= target_window_limit;
            off_fault_ramp_time: prdata <= fault_ramp_time;
            off_brake_close_frequency: prdata <= {16'h0, brake_close_frequency};
            off_commanded_position: prdata <= commanded_position;
            off_selected_target_position: prdata <= selected_target_position;
            off_present_position: prdata <= present_position;
            off_preset_position: prdata <= preset_position;
            off_homing_speed: prdata <= {16'h0, homing_speed};
            off_homing_ramp: prdata <= homing_ramp;
            off_output_level: prdata <= {16'h0, level};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   a_coast_blocks_now: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && state == st_run && any_fault && !control[ctl_fault_stop_select])
      |=> blocked) else $error("Coast did not block.");
   a_coast_brake_same: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && state == st_run && any_fault && !control[ctl_fault_stop_select]
      && control[ctl_brake_enable]) |=> brake && blocked) else $error("Brake late.");
   a_ramp_enters: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && state == st_run && any_fault && control[ctl_fault_stop_select])
      |=> state == st_ramp) else $error("Ramp stop not taken.");
   a_ramp_not_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      (state == st_ramp && level != 16'h0000) |-> !blocked) else $error("Ramp blocked.");
   a_upper_soft_off: assert property (@(posedge pclk) disable iff (!presetn)
      !control[ctl_upper_soft_bound_en] |-> !events[ev_upper_soft]) else $error("Upper soft.");
   a_lower_soft_off: assert property (@(posedge pclk) disable iff (!presetn)
      !control[ctl_lower_soft_bound_en] |-> !events[ev_lower_soft]) else $error("Lower soft.");
   a_soft_level_locked: assert property (@(posedge pclk) disable iff (!presetn)
      !control[ctl_soft_bound_function] |=> $stable(upper_soft_bound_level))
      else $error("Soft level changed.");
   a_tracking_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !running |-> !events[ev_tracking]) else $error("Tracking fault idle.");
   a_home_stops: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && home_load) |=> state == st_stopped) else $error("Home not stopped.");
endmodule : position_fault_stop_logic

// ===== design/quad_counter.sv
`timescale 1ns/1ps
module quad_counter
   import pos_fault_pkg::*;
(
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic enc_a, // Encoder channel A.
   input wire logic enc_b, // Encoder channel B.
   input wire logic load, // Load position pulse.
   input wire logic [31:0] load_value, // Value to load.
   output logic [31:0] position // Present position.
);
   logic [1:0] prev_ab;
   logic [1:0] ab;

   assign ab = {enc_a, enc_b};

   // Four-times decoding: each legal edge of either channel counts one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ab <= 2'h0;
         position <= 32'h0000_0000;
      end else if (ce) begin
         prev_ab <= ab;
         if (load) begin
            position <= load_value;
         end else if ((prev_ab ^ ab) == 2'h3 || ab == prev_ab) begin
            position <= position;
         end else if ((prev_ab[1] ^ ab[0]) == 1'b1) begin
            position <= position + 32'h0000_0001;
         end else begin
            position <= position - 32'h0000_0001;
         end
      end
   end

   a_load_takes_value: assert property (@(posedge pclk) disable iff (!presetn)
      (ce && load) |=> position == $past(load_value)) else $error("Position load lost.");
endmodule : quad_counter

// ===== shared/pos_fault_pkg.sv
package pos_fault_pkg;
   localparam logic [11:0] off_control = 12'h000;
   localparam logic [11:0] off_status = 12'h004;
   localparam logic [11:0] off_irq_status = 12'h008;
   localparam logic [11:0] off_irq_mask = 12'h00c;
   localparam logic [11:0] off_upper_soft_bound_level = 12'h010;
   localparam logic [11:0] off_lower_soft_bound_level = 12'h014;
   localparam logic [11:0] off_tracking_error_limit = 12'h018;
   localparam logic [11:0] off_target_window_limit = 12'h01c;
   localparam logic [11:0] off_fault_ramp_time = 12'h020;
   localparam logic [11:0] off_brake_close_frequency = 12'h024;
   localparam logic [11:0] off_commanded_position = 12'h028;
   localparam logic [11:0] off_selected_target_position = 12'h02c;
   localparam logic [11:0] off_present_position = 12'h030;
   localparam logic [11:0] off_preset_position = 12'h034;
   localparam logic [11:0] off_homing_speed = 12'h038;
   localparam logic [11:0] off_homing_ramp = 12'h03c;
   localparam logic [11:0] off_output_level = 12'h040;
   // Control register bit positions.
   localparam int ctl_fault_stop_select = 0;
   localparam int ctl_upper_soft_bound_en = 1;
   localparam int ctl_lower_soft_bound_en = 2;
   localparam int ctl_soft_bound_function = 3;
   localparam int ctl_brake_enable = 4;
   localparam int ctl_homing_method_lo = 5;
   localparam int ctl_run = 7;
   // Interrupt / fault bit positions.
   localparam int ev_upper_hard = 0;
   localparam int ev_lower_hard = 1;
   localparam int ev_upper_soft = 2;
   localparam int ev_lower_soft = 3;
   localparam int ev_tracking = 4;
   localparam int ev_target = 5;
   localparam int ev_stop_done = 6;
   localparam int ev_home_done = 7;
   localparam int ev_width = 8;
   localparam logic [31:0] control_reset = 32'h0000_0000;
   localparam logic [31:0] ramp_time_reset = 32'h0000_0064;
   localparam logic [31:0] limit_reset = 32'h7fff_ffff;
   localparam logic [15:0] full_output = 16'hffff;
   localparam int homing_slow_percent = 20;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_run = 3'b001,
      st_ramp = 3'b010,
      st_stopped = 3'b011,
      st_home_fast = 3'b100,
      st_home_slow = 3'b101
   } stop_state_type;

   typedef struct packed {
      logic upper_hard;
      logic lower_hard;
      logic enc_a;
      logic enc_b;
      logic enc_index;
      logic run_home;
      logic home_switch;
   } field_in_type;

   typedef struct packed {
      logic gate_block;
      logic brake_close;
      logic [15:0] output_level;
      logic dir_reverse;
   } drive_out_type;

   function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] d;
      d = a - b;
      return d[31] ? (32'h0000_0000 - d) : d;
   endfunction : abs_diff
endpackage : pos_fault_pkg

// ===== testbench/field_model.sv
`timescale 1ns/1ps
module field_model
   import pos_fault_pkg::*;
(
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic start, // Pulse that begins a move.
   input wire logic dir_fwd, // High moves forward.
   input wire logic [7:0] steps, // Encoder edges to produce.
   input wire logic [3:0] switches, // Upper, lower, run home, home switch.
   output logic busy, // Move in progress.
   output field_in_type field_in // Lines seen by the block.
);
   logic [1:0] phase;
   logic [7:0] left;
   logic [1:0] pace;
   // Edges come three cycles apart, slower than the block needs, so no level is missed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 2'h0;
         left <= 8'h00;
         pace <= 2'h0;
      end else if (start) begin
         left <= steps;
         pace <= 2'h0;
      end else if (left != 8'h00) begin
         pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
         if (pace == 2'h2) begin
            // Forward lets B lead A, the sense in which the block counts up.
            phase <= dir_fwd ? phase - 2'h1 : phase + 2'h1;
            left <= left - 8'h01;
         end
      end
   end
   assign busy = (left != 8'h00);
   assign field_in = '{upper_hard: switches[3], lower_hard: switches[2], enc_a: ^phase,
      enc_b: phase[1], enc_index: busy && (phase == 2'h0), run_home: switches[1],
      home_switch: switches[0]};
endmodule : field_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench
   import pos_fault_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, pb;
   logic start, dir_fwd, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, pos, x;
   logic [7:0] steps;
   logic [3:0] switches;
   field_in_type field_in;
   drive_out_type drive_out;
   integer error_cnt, num_checks, seed, n, i;
   position_fault_stop_logic i_position_fault_stop_logic (.pclk(pclk), .presetn(presetn),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .field_in(field_in), .drive_out(drive_out), .irq(irq));
   field_model i_field_model (.pclk(pclk), .presetn(presetn), .start(start),
      .dir_fwd(dir_fwd), .steps(steps), .switches(switches), .busy(busy), .field_in(field_in));
   function automatic logic [31:0] moved(input logic [31:0] p, input integer k, input bit f);
      return f ? p + k : p - k;
   endfunction : moved
   task check(input logic [31:0] seen, input logic [31:0] expv);
      num_checks = num_checks + 1;
      if (seen !== expv) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task sw(input logic [3:0] s);
      @(posedge pclk);
      switches <= s;
      repeat (4) @(negedge pclk);
   endtask : sw
   task move(input integer k, input bit f);
      @(posedge pclk);
      start <= 1'b1;
      steps <= k[7:0];
      dir_fwd <= f;
      @(posedge pclk);
      start <= 1'b0;
      repeat (2) @(negedge pclk);
      while (busy === 1'b1) @(negedge pclk);
      repeat (4) @(negedge pclk);
   endtask : move
   task test_done;
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (90000) @(posedge pclk);
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      {presetn, psel, penable, pwrite, start, dir_fwd} = 6'h00;
      {paddr, pwdata, steps, switches} = '0;
      error_cnt = 0;
      num_checks = 0;
      seed = 32'ha530;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check({irq, drive_out.gate_block, drive_out.brake_close}, 32'h3);
      apb(1'b0, off_fault_ramp_time, 0);
      check(rd, ramp_time_reset);
      apb(1'b0, 12'h0fc, 0);
      check(rd, 32'h0);
      check(err, 1'b1);
      wr(off_upper_soft_bound_level, 32'h0000_1234);
      apb(1'b0, off_upper_soft_bound_level, 0);
      check(rd, limit_reset);
      wr(off_control, 32'h08);
      wr(off_upper_soft_bound_level, 32'h0000_1234);
      apb(1'b0, off_upper_soft_bound_level, 0);
      check(rd, 32'h0000_1234);
      apb(1'b0, off_present_position, 0);
      pos = rd;
      for (i = 0; i < 4; i++) begin
         n = ($random(seed) & 15) + 4;
         move(n, i[0]);
         pos = moved(pos, n, i[0]);
         apb(1'b0, off_present_position, 0);
         check(rd, pos);
      end
      pos = $random(seed);
      wr(off_present_position, pos);
      apb(1'b0, off_present_position, 0);
      check(rd, pos);
      wr(off_target_window_limit, 32'h3);
      wr(off_selected_target_position, pos + 32'h3);
      wr(off_irq_status, 32'hff);
      apb(1'b0, off_irq_status, 0);
      check(rd[ev_target], 1'b0);
      wr(off_selected_target_position, pos - 32'h4);
      apb(1'b0, off_irq_status, 0);
      check(rd[ev_target], 1'b1);
      wr(off_selected_target_position, pos);
      wr(off_target_window_limit, limit_reset);
      wr(off_commanded_position, pos);
      // Both soft levels straddle the position so only the enables decide.
      wr(off_upper_soft_bound_level, pos - (($random(seed) & 255) + 1));
      wr(off_lower_soft_bound_level, pos + (($random(seed) & 255) + 1));
      wr(off_irq_status, 32'hff);
      wr(off_control, 32'h88);
      repeat (4) @(negedge pclk);
      check(drive_out.gate_block, 1'b0);
      apb(1'b0, off_irq_status, 0);
      check(rd[3:2], 2'b00);
      for (i = 0; i < 2; i++) begin
         wr(off_control, 32'h0);
         wr(off_irq_status, 32'hff);
         wr(off_control, 32'h8a + 2 * i);
         repeat (4) @(negedge pclk);
         check(drive_out.gate_block, 1'b1);
         apb(1'b0, off_status, 0);
         check(rd[7:0], 8'h04 << i);
      end
      wr(off_upper_soft_bound_level, limit_reset);
      wr(off_lower_soft_bound_level, 32'h8000_0000);
      wr(off_control, 32'h0);
      wr(off_irq_status, 32'hff);
      wr(off_control, 32'h90);
      sw(4'h0);
      check(drive_out.gate_block, 1'b0);
      sw(4'h8);
      check({drive_out.gate_block, drive_out.brake_close}, 2'b11);
      apb(1'b0, off_status, 0);
      check(rd[7:0], 8'h01);
      wr(off_irq_mask, 32'h01);
      sw(4'h0);
      check(irq, 1'b1);
      wr(off_irq_status, 32'hff);
      sw(4'h0);
      check(irq, 1'b0);
      wr(off_control, 32'h0);
      wr(off_irq_status, 32'hff);
      wr(off_fault_ramp_time, 32'h1);
      wr(off_brake_close_frequency, 32'ha);
      wr(off_output_level, 32'h28);
      wr(off_tracking_error_limit, 32'h5);
      wr(off_control, 32'h91);
      repeat (4) @(negedge pclk);
      pb = drive_out.brake_close;
      wr(off_commanded_position, pos + 6 + ($random(seed) & 7));
      for (i = 0; i < 70000 && drive_out.gate_block !== 1'b1; i++) begin
         @(negedge pclk);
         if (drive_out.brake_close === 1'b1 && pb !== 1'b1)
            check(drive_out.output_level <= 16'ha, 1'b1);
         pb = drive_out.brake_close;
      end
      check({drive_out.output_level, drive_out.brake_close}, 17'h1);
      apb(1'b0, off_status, 0);
      check(rd[7:0], 8'h10);
      wr(off_control, 32'h0);
      wr(off_irq_status, 32'hff);
      x = $random(seed);
      wr(off_preset_position, x);
      wr(off_homing_speed, 32'h64);
      wr(off_control, 32'h20);
      sw(4'h2);
      check({drive_out.dir_reverse, drive_out.output_level}, 32'h1_0064);
      sw(4'h3);
      check({drive_out.dir_reverse, drive_out.output_level}, homing_slow_percent);
      sw(4'h2);
      sw(4'h0);
      for (i = 0; i < 200 && rd[ev_home_done] !== 1'b1; i++) apb(1'b0, off_irq_status, 0);
      check(rd[ev_home_done], 1'b1);
      apb(1'b0, off_present_position, 0);
      check(rd, x);
      // Index homing: the reference waits for the first index pulse after the home switch.
      wr(off_control, 32'h0);
      wr(off_irq_status, 32'hff);
      x = $random(seed);
      wr(off_preset_position, x);
      sw(4'h2);
      sw(4'h3);
      sw(4'h2);
      apb(1'b0, off_irq_status, 0);
      check(rd[ev_home_done], 1'b0);
      // The load lands on the step that reaches phase zero; later steps still count.
      x = x + 4 - i_field_model.phase;
      move(4, 1'b1);
      sw(4'h0);
      apb(1'b0, off_irq_status, 0);
      check(rd[ev_home_done], 1'b1);
      apb(1'b0, off_present_position, 0);
      check(rd, x);
      test_done;
   end
endmodule : testbench
